// ### logic/mcuid_params.svh
// Constants for the instruction decoder: field positions, opcodes, timing.
// Assumes inclusion by the decoder package and modules only.
`ifndef MCUID_PARAMS_SVH
`define MCUID_PARAMS_SVH

`define MCUID_WORD_W        14
`define MCUID_FILE_W        7
`define MCUID_BIT_W         3
`define MCUID_LIT8_W        8
`define MCUID_LIT11_W       11
`define MCUID_DEST_POS      7
`define MCUID_FILE_MAX      7'h7f
`define MCUID_OSC_PER_CYC   4
`define MCUID_RST_PHASE     2'h0
`define MCUID_LEGACY_OPT    14'h0062
`define MCUID_LEGACY_DIR_LO 14'h0065
`define MCUID_LEGACY_DIR_HI 14'h0067

`endif

// ### logic/mcuid_pkg.sv
// Types shared by the instruction decoder.
// Assumes the params header sits beside it.
`default_nettype none
package mcuid_pkg;
    typedef enum logic [1:0] {
        MCUID_CLS_BYTE = 2'h0,
        MCUID_CLS_BIT  = 2'h1,
        MCUID_CLS_LIT  = 2'h2
    } mcuid_class_t;

    typedef enum logic [1:0] {
        MCUID_ST_RUN   = 2'h0,
        MCUID_ST_FLUSH = 2'h1
    } mcuid_state_t;
endpackage
`default_nettype wire

// ### logic/mcuid_field_reg.sv
// Registered field extractor for one instruction word.
// Assumes word and load come from the same clock domain.
`default_nettype none
`include "mcuid_params.svh"
module mcuid_field_reg
    import mcuid_pkg::*;
(
    input  wire logic                       sys_clk,
    input  wire logic                       srst,
    input  wire logic                       load,
    input  wire logic [`MCUID_WORD_W-1:0]   word,
    output logic      [`MCUID_FILE_W-1:0]   file_addr,
    output logic                            dest_file,
    output logic      [`MCUID_BIT_W-1:0]    bit_sel,
    output logic      [`MCUID_LIT8_W-1:0]   lit8,
    output logic      [`MCUID_LIT11_W-1:0]  lit11
);
    always_ff @(posedge sys_clk) begin
        if (srst) begin
            file_addr <= '0;
            dest_file <= 1'b0;
            bit_sel   <= '0;
            lit8      <= '0;
            lit11     <= '0;
        end else if (load) begin
            file_addr <= word[6:0];
            dest_file <= word[`MCUID_DEST_POS];
            bit_sel   <= word[9:7];
            lit8      <= word[7:0];
            lit11     <= word[10:0];
        end
    end
endmodule
`default_nettype wire

// ### logic/mcuid_decoder.sv
// Instruction decoder: classifies 14-bit words and sequences instruction cycles.
// Assumes fetch presents a word each cycle start and the datapath reports test result.
`default_nettype none
`include "mcuid_params.svh"
// Overview of operation
// - Accept one 14-bit word per instruction
// - Classify into byte, bit or literal class
// - Destination zero accumulator, one file register
// - File address spans 0x00 through 0x7F
// - Bit select picks one of eight bits
// - Literal eight bits, eleven for call/jump
// - Instruction cycle is four oscillator periods
// - Taken test or PC change takes two
// - Every file operand is read first
// - Port clear still reads, resetting mismatch
// - Don't-care bits never change decoding
// - Byte format opcode, d, 7-bit f
// - Bit format opcode, 3-bit b, f
// - Literal format opcode, 8-bit k
// - Call/jump format opcode, 11-bit k
module mcuid_decoder
    import mcuid_pkg::*;
(
    input  wire logic                       sys_clk,
    input  wire logic                       srst,
    input  wire logic [`MCUID_WORD_W-1:0]   instr_word,
    input  wire logic                       test_true,
    output logic      [1:0]                 osc_phase,
    output logic                            cycle_start,
    output logic      [1:0]                 instr_class,
    output logic      [`MCUID_FILE_W-1:0]   file_addr,
    output logic                            dest_file,
    output logic      [`MCUID_BIT_W-1:0]    bit_sel,
    output logic      [`MCUID_LIT8_W-1:0]   lit8,
    output logic      [`MCUID_LIT11_W-1:0]  lit11,
    output logic                            uses_file,
    output logic                            file_read,
    output logic                            file_write,
    output logic                            acc_write,
    output logic                            is_call_jump,
    output logic                            is_skip,
    output logic                            pc_change,
    output logic                            two_cycle,
    output logic                            exec_nop,
    output logic                            legacy_op
);
    mcuid_state_t state;
    mcuid_state_t next_state;
    logic [1:0]   next_phase;
    logic [1:0]   cls_q;
    logic         uses_file_q;
    logic         wr_file_q;
    logic         wr_acc_q;
    logic         skip_q;
    logic         pcchg_q;
    logic         cj_q;
    logic         legacy_q;
    logic         exec_q;

    // Classification helper
    function automatic logic [1:0] class_of(input logic [`MCUID_WORD_W-1:0] w);
        case (w[13:12])
            2'h0:    class_of = MCUID_CLS_BYTE;
            2'h1:    class_of = MCUID_CLS_BIT;
            default: class_of = MCUID_CLS_LIT;
        endcase
    endfunction

    // Word with don't-care positions forced to zero
    function automatic logic [`MCUID_WORD_W-1:0] canon(input logic [`MCUID_WORD_W-1:0] w);
        logic [`MCUID_WORD_W-1:0] c;
        c = w;
        if (w[13:8] == 6'h01 && !w[7]) begin
            c[6:0] = 7'h00;
        end
        if (w[13:8] == 6'h00 && !w[7] && w[4:0] == 5'h00) begin
            c[6:5] = 2'h0;
        end
        if (w[13:10] == 4'hf && w[9]) begin
            c[8] = 1'b0;
        end
        if (w[13:10] == 4'hf && !w[9] && w[8]) begin
            c[8] = 1'b0;
        end
        if (w[13:10] == 4'hc || w[13:10] == 4'hd) begin
            c[9:8] = 2'h0;
        end
        canon = c;
    endfunction

    wire [`MCUID_WORD_W-1:0] cw         = canon(instr_word);
    wire [1:0]               w_class    = class_of(cw);
    wire                     w_byte     = (w_class == MCUID_CLS_BYTE);
    wire                     w_bit      = (w_class == MCUID_CLS_BIT);
    wire                     w_cj       = (cw[13:12] == 2'h2);
    wire                     w_misc     = w_byte && cw[11:7] == 5'h00;
    wire                     w_ret      = w_misc && (cw[6:0] == 7'h08 || cw[6:0] == 7'h09);
    wire                     w_retlw    = (cw[13:10] == 4'hd);
    wire                     w_clrw     = w_byte && cw[11:8] == 4'h1 && !cw[7];
    wire                     w_bitop    = w_bit && !cw[11];
    wire                     w_bittest  = w_bit && cw[11];
    wire                     w_skipop   = (w_byte && (cw[11:8] == 4'hb || cw[11:8] == 4'hf))
                                          || w_bittest;
    wire                     w_file     = (w_byte && !w_misc && !w_clrw) || w_bit;
    wire                     w_wfile    = (w_byte && cw[7] && !w_misc && !w_clrw) || w_bitop;
    wire                     w_wacc     = (w_byte && !cw[7] && !w_misc)
                                          || (w_class == MCUID_CLS_LIT && !w_cj);
    wire                     w_pcchg    = w_cj || w_ret || w_retlw;
    wire                     w_legacy   = (cw == `MCUID_LEGACY_OPT)
                                          || (cw >= `MCUID_LEGACY_DIR_LO
                                              && cw <= `MCUID_LEGACY_DIR_HI);

    wire                     last_phase = (osc_phase == 2'(`MCUID_OSC_PER_CYC - 1));
    wire                     load_word  = (osc_phase == `MCUID_RST_PHASE)
                                          && (state == MCUID_ST_RUN);
    wire                     taken      = exec_q && (pcchg_q || (skip_q && test_true));

    mcuid_field_reg u_fields (
        .sys_clk   (sys_clk),
        .srst      (srst),
        .load      (load_word),
        .word      (cw),
        .file_addr (file_addr),
        .dest_file (dest_file),
        .bit_sel   (bit_sel),
        .lit8      (lit8),
        .lit11     (lit11)
    );

    assign next_phase = last_phase ? `MCUID_RST_PHASE : osc_phase + 2'h1;

    always_comb begin
        next_state = state;
        case (state)
            MCUID_ST_RUN:   if (last_phase && taken) next_state = MCUID_ST_FLUSH;
            MCUID_ST_FLUSH: if (last_phase) next_state = MCUID_ST_RUN;
            default:        next_state = MCUID_ST_RUN;
        endcase
    end

    always_ff @(posedge sys_clk) begin
        if (srst) begin
            osc_phase <= `MCUID_RST_PHASE;
            state     <= MCUID_ST_RUN;
        end else begin
            osc_phase <= next_phase;
            state     <= next_state;
        end
    end

    always_ff @(posedge sys_clk) begin
        if (srst) begin
            cls_q       <= MCUID_CLS_BYTE;
            uses_file_q <= 1'b0;
            wr_file_q   <= 1'b0;
            wr_acc_q    <= 1'b0;
            skip_q      <= 1'b0;
            pcchg_q     <= 1'b0;
            cj_q        <= 1'b0;
            legacy_q    <= 1'b0;
            exec_q      <= 1'b0;
        end else if (osc_phase == `MCUID_RST_PHASE) begin
            exec_q      <= load_word;
            if (load_word) begin
                cls_q       <= w_class;
                uses_file_q <= w_file;
                wr_file_q   <= w_wfile;
                wr_acc_q    <= w_wacc;
                skip_q      <= w_skipop;
                pcchg_q     <= w_pcchg;
                cj_q        <= w_cj;
                legacy_q    <= w_legacy;
            end
        end
    end

    assign cycle_start  = (osc_phase == `MCUID_RST_PHASE);
    assign instr_class  = cls_q;
    assign uses_file    = exec_q && uses_file_q;
    // Read of every file operand, even write-only ones like clear
    assign file_read    = uses_file && (osc_phase == 2'h1);
    assign file_write   = exec_q && wr_file_q && last_phase;
    assign acc_write    = exec_q && wr_acc_q && last_phase;
    assign is_call_jump = exec_q && cj_q;
    assign is_skip      = exec_q && skip_q;
    assign pc_change    = exec_q && pcchg_q;
    assign two_cycle    = taken;
    assign exec_nop     = (state == MCUID_ST_FLUSH);
    assign legacy_op    = exec_q && legacy_q;
endmodule
`default_nettype wire

// ### verification/mcuid_decoder_properties.sv
// Port timing checker for the instruction decoder.
// Assumes it is bound onto every decoder instance.
`default_nettype none
module mcuid_decoder_chk (
    input wire logic       sys_clk,
    input wire logic       srst,
    input wire logic [1:0] osc_phase,
    input wire logic       cycle_start,
    input wire logic [1:0] instr_class,
    input wire logic [6:0] file_addr,
    input wire logic       dest_file,
    input wire logic       uses_file,
    input wire logic       file_read,
    input wire logic       file_write,
    input wire logic       acc_write,
    input wire logic       is_call_jump,
    input wire logic       pc_change,
    input wire logic       two_cycle,
    input wire logic       exec_nop
);
    default clocking @(posedge sys_clk); endclocking
    default disable iff (srst);
    chk_phase_step: assert property (1 |=> osc_phase == 2'($past(osc_phase) + 2'h1))
        else $error("phase did not advance");
    chk_start_every: assert property (cycle_start |=> !cycle_start [*3] ##1 cycle_start)
        else $error("cycle start not every four clocks");
    chk_read_phase: assert property (file_read |-> osc_phase == 2'h1 && uses_file)
        else $error("file read outside phase one");
    chk_write_read: assert property (file_write |-> osc_phase == 2'h3 && $past(file_read, 2))
        else $error("file write without prior read");
    chk_dest_route: assert property (osc_phase == 2'h3 && instr_class == 2'h0 && uses_file
        && !exec_nop |-> file_write == dest_file && acc_write == !dest_file)
        else $error("result routed to wrong place");
    chk_flush_len: assert property (two_cycle && osc_phase == 2'h3 |=> exec_nop [*4] ##1 !exec_nop)
        else $error("flushed cycle length wrong");
    chk_nop_quiet: assert property (exec_nop && !cycle_start |-> !(file_read || file_write
        || acc_write
        || two_cycle || pc_change))
        else $error("activity during flushed cycle");
    chk_class_legal: assert property (instr_class != 2'h3)
        else $error("illegal class code");
    chk_fields_hold: assert property (osc_phase != 2'h0 |=> $stable(file_addr) && $stable(dest_file))
        else $error("fields changed without a load");
    chk_jump_pc: assert property (is_call_jump |-> pc_change && instr_class == 2'h2)
        else $error("call or jump without pc change");
endmodule
bind mcuid_decoder mcuid_decoder_chk u_chk (.sys_clk(sys_clk), .srst(srst), .osc_phase(osc_phase),
    .cycle_start(cycle_start), .instr_class(instr_class), .file_addr(file_addr),
    .dest_file(dest_file), .uses_file(uses_file), .file_read(file_read), .file_write(file_write),
    .acc_write(acc_write), .is_call_jump(is_call_jump), .pc_change(pc_change),
    .two_cycle(two_cycle), .exec_nop(exec_nop));
`default_nettype wire

// ### verification/mcuid_fetch_model.sv
// Fetch path and datapath stand-in for the decoder bench.
// Assumes the bench sets the queued word before phase 0.
`default_nettype none
module mcuid_fetch_model (
    input  wire logic [1:0]  osc_phase,
    input  wire logic [13:0] word_q,
    input  wire logic        test_q,
    output logic      [13:0] instr_word,
    output logic             test_true
);
    timeunit 1ns;
    timeprecision 1ps;
    // Word valid in phase 0 only
    assign instr_word = (osc_phase == 2'h0) ? word_q : ~word_q;
    // Test result valid in phase 3 only
    assign test_true = (osc_phase == 2'h3) ? test_q : ~test_q;
endmodule
`default_nettype wire

// ### verification/tb_mcu_instruction_decoder.sv
// Self-checking bench for the instruction decoder against a field model.
// Assumes decoder, package, checker and fetch model are compiled first.
`default_nettype none
module tb_mcu_instruction_decoder;
    timeunit 1ns;
    timeprecision 1ps;
    logic        sys_clk = 1'b0, srst = 1'b1, test_q = 1'b0, tt;
    logic [13:0] word_q = 14'h0000, instr_word, w;
    logic [1:0]  osc_phase, instr_class;
    logic [6:0]  file_addr;
    logic [2:0]  bit_sel;
    logic [7:0]  lit8;
    logic [10:0] lit11;
    logic        test_true, dest_file, file_read, file_write, two_cycle, exec_nop;
    logic        cycle_start, uses_file, acc_write, is_call_jump, is_skip, pc_change;
    logic        legacy_op;
    logic [13:0] dir [9] = '{14'h2123, 14'h2f55, 14'h0008, 14'h0009, 14'h3455,
                             14'h0b85, 14'h1a33, 14'h1f90, 14'h3355};
    int          miscompares = 0, num_checks = 0;

    always #2 sys_clk = ~sys_clk;

    mcuid_fetch_model u_fetch (.osc_phase(osc_phase), .word_q(word_q), .test_q(test_q),
        .instr_word(instr_word), .test_true(test_true));
    mcuid_decoder DUT (.sys_clk(sys_clk), .srst(srst), .instr_word(instr_word),
        .test_true(test_true), .osc_phase(osc_phase), .cycle_start(cycle_start),
        .instr_class(instr_class), .file_addr(file_addr), .dest_file(dest_file),
        .bit_sel(bit_sel), .lit8(lit8), .lit11(lit11), .uses_file(uses_file),
        .file_read(file_read), .file_write(file_write), .acc_write(acc_write),
        .is_call_jump(is_call_jump), .is_skip(is_skip), .pc_change(pc_change),
        .two_cycle(two_cycle), .exec_nop(exec_nop), .legacy_op(legacy_op));

    task cmp_val(input logic [13:0] got, input logic [13:0] exp);
        num_checks++;
        if (got !== exp) begin
            miscompares++;
            $display("unexpected t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    task cmp_flag(input logic got, input logic exp);
        cmp_val({13'h0, got}, {13'h0, exp});
    endtask

    task wrap_up;
        $display("checks=%0d miscompares=%0d", num_checks, miscompares);
        if (miscompares == 0 && num_checks > 0) $display("No errors found");
        else $display("Errors were found");
        $finish;
    endtask

    // One instruction through the model and the decoder
    task run(input logic [13:0] v, input logic t);
        int cls, fop, two, n, acc, pcc, skp;
        n = 0;
        do begin
            @(posedge sys_clk);
            n++;
        end while (!(osc_phase === 2'h3 && two_cycle !== 1'b1) && n < 20);
        word_q <= v;
        test_q <= t;
        cls = (v[13:12] == 2'h0) ? 0 : (v[13:12] == 2'h1) ? 1 : 2;
        fop = (cls == 1) || (cls == 0 && (v[11:8] != 0 || v[7]) && v[11:7] != 5'h02);
        two = (v[13:12] == 2'h2 || v[13:10] == 4'hd || v == 14'h0008 || v == 14'h0009)
            || (t && (v[13:8] == 6'h0b || v[13:8] == 6'h0f || v[13:11] == 3'h3));
        skp = (v[13:8] == 6'h0b || v[13:8] == 6'h0f || v[13:11] == 3'h3);
        pcc = (v[13:12] == 2'h2 || v[13:10] == 4'hd || v == 14'h0008 || v == 14'h0009);
        acc = (cls == 0 && !v[7] && v[11:8] != 4'h0) || (v[13:12] == 2'h3);
        @(posedge sys_clk);
        #1;
        cmp_val(14'(instr_class), 14'(cls));
        cmp_flag(file_read, fop[0]);
        cmp_flag(uses_file, fop[0]);
        cmp_flag(is_call_jump, v[13:12] == 2'h2);
        cmp_flag(is_skip, skp[0]);
        cmp_flag(pc_change, pcc[0]);
        cmp_flag(legacy_op, 1'b0);
        cmp_flag(cycle_start, 1'b0);
        if (fop) cmp_val(14'(file_addr), 14'(v[6:0]));
        if (cls == 0 && fop) cmp_flag(dest_file, v[7]);
        if (cls == 1) cmp_val(14'(bit_sel), 14'(v[9:7]));
        if (v[13:12] == 2'h2) cmp_val(14'(lit11), 14'(v[10:0]));
        else if (cls == 2) cmp_val(14'(lit8), 14'(v[7:0]));
        repeat (2) @(posedge sys_clk);
        if (two) word_q <= ~v;
        #1;
        cmp_flag(two_cycle, two[0]);
        if (fop) cmp_flag(file_write, cls == 0 ? v[7] : !v[11]);
        cmp_flag(acc_write, acc[0]);
        if (two) begin
            @(posedge sys_clk);
            #1;
            cmp_flag(exec_nop, 1'b1);
            cmp_flag(cycle_start, 1'b1);
        end
    endtask

    initial begin
        void'($urandom(47505));
        repeat (12) @(posedge sys_clk);
        srst <= 1'b0;
        foreach (dir[i]) begin
            run(dir[i], 1'b1);
            run(dir[i], 1'b0);
        end
        for (int i = 0; i < 80; i++) begin
            w = 14'($urandom);
            tt = 1'($urandom);
            if (w[6:0] == 7'h02) w[0] = 1'b1;
            if (w inside {14'h0062, [14'h0065:14'h0067]}) w = 14'h0000;
            run(w, tt);
        end
        wrap_up();
    end

    initial begin
        #40000;
        miscompares++;
        wrap_up();
    end
endmodule
`default_nettype wire
